// File: verilog/jmc_pkg.sv
package jmc_pkg;
  // Clock and pause time unit
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PAUSE_UNIT_NS = 1000000;
  localparam int unsigned CYCLES_PER_MS = (PAUSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Parameter addresses
  localparam logic [15:0] OFS_SLOW_SPEED = 16'h2908;
  localparam logic [15:0] OFS_FAST_SPEED = 16'h290a;
  localparam logic [15:0] OFS_STEP_DIST = 16'h290e;
  localparam logic [15:0] OFS_PAUSE_TIME = 16'h2910;
  // Reset values
  localparam logic [15:0] RST_SLOW_SPEED = 16'h003c;
  localparam logic [15:0] RST_FAST_SPEED = 16'h00b4;
  localparam logic [31:0] RST_STEP_DIST = 32'h00000001;
  localparam logic [15:0] RST_PAUSE_TIME = 16'h01f4;
  localparam logic [2:0] RST_MOVE_REQ = 3'h0;
  // Value ranges
  localparam logic [15:0] SPEED_MIN = 16'h0001;
  localparam logic [15:0] SPEED_MAX = 16'h3390;
  localparam logic [15:0] PAUSE_MIN = 16'h0001;
  localparam logic [15:0] PAUSE_MAX = 16'h7fff;
  localparam logic [15:0] MOVE_REQ_MAX = 16'h0007;
  // Mode select and status bytes
  localparam logic [3:0] MODE_JOG = 4'h1;
  localparam logic [3:0] MODE_HOMING = 4'h2;
  localparam logic [3:0] MODE_PROFILE_POS = 4'h3;
  localparam logic [3:0] MODE_PROFILE_VEL = 4'h4;
  localparam logic [3:0] MODE_SPEED_CTRL = 4'h7;
  localparam logic [2:0] JOG_ACTION = 3'h0;
  localparam int unsigned MSB_ACTION_LO = 4;
  localparam int unsigned MSB_ACTION_HI = 6;
  localparam int unsigned MSB_TOGGLE = 7;
  localparam int unsigned MSTAT_REJECT = 6;
  // Move request bits
  localparam int unsigned REQ_POS = 0;
  localparam int unsigned REQ_NEG = 1;
  localparam int unsigned REQ_FAST = 2;
  // Drive status word bits
  localparam int unsigned DST_INFO = 13;
  localparam int unsigned DST_END = 14;
  localparam int unsigned DST_ERR = 15;
  typedef enum logic [2:0] {ST_IDLE, ST_STEP, ST_PAUSE, ST_CONT, ST_STOP} jmc_seq_state_t;
  typedef enum logic [2:0] {RI_NONE, RI_SLOW, RI_FAST, RI_DIST, RI_PAUSE} jmc_reg_idx_t;
endpackage

// File: verilog/jmc_seq_if.sv
`timescale 1ns/100ps
`default_nettype none
interface jmc_seq_if;
  logic req_pos;
  logic req_neg;
  logic step_mode;
  logic abort;
  logic pos_reached;
  logic standstill;
  logic tick_ms;
  logic [15:0] pause_ms;
  logic step_start;
  logic run_cont;
  logic dir_neg;
  logic busy;
  modport ctrl (output req_pos, output req_neg, output step_mode, output abort,
    output pos_reached, output standstill, output tick_ms, output pause_ms,
    input step_start, input run_cont, input dir_neg, input busy);
  modport seq (input req_pos, input req_neg, input step_mode, input abort,
    input pos_reached, input standstill, input tick_ms, input pause_ms,
    output step_start, output run_cont, output dir_neg, output busy);
endinterface
`default_nettype wire

// File: verilog/jmc_step_seq.sv
`timescale 1ns/100ps
`default_nettype none
module jmc_step_seq (
  input wire logic clk,
  input wire logic rst,
  jmc_seq_if.seq sif
);
  jmc_pkg::jmc_seq_state_t state;
  logic [15:0] pause_cnt;
  logic held;
  logic start_ok;

  assign held = sif.dir_neg ? sif.req_neg : sif.req_pos;
  assign start_ok = !sif.abort && (sif.req_pos ^ sif.req_neg);
  assign sif.busy = (state != jmc_pkg::ST_IDLE);
  assign sif.run_cont = (state == jmc_pkg::ST_CONT);

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= jmc_pkg::ST_IDLE;
    else
      case (state)
        jmc_pkg::ST_IDLE:
          if (start_ok)
            state <= sif.step_mode ? jmc_pkg::ST_STEP : jmc_pkg::ST_CONT;
        jmc_pkg::ST_STEP:
          if (sif.abort)
            state <= jmc_pkg::ST_STOP;
          else if (sif.pos_reached)
            state <= held ? jmc_pkg::ST_PAUSE : jmc_pkg::ST_STOP;
        jmc_pkg::ST_PAUSE:
          if (sif.abort || !held)
            state <= jmc_pkg::ST_STOP;
          else if (sif.tick_ms && pause_cnt <= 16'h0001)
            state <= jmc_pkg::ST_CONT;
        jmc_pkg::ST_CONT:
          if (sif.abort || !held)
            state <= jmc_pkg::ST_STOP;
        jmc_pkg::ST_STOP:
          if (sif.standstill)
            state <= jmc_pkg::ST_IDLE;
        default:
          state <= jmc_pkg::ST_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sif.dir_neg <= 1'b0;
    else if (state == jmc_pkg::ST_IDLE && start_ok)
      sif.dir_neg <= sif.req_neg;
  end

  // Pause latched at start, so a change only counts from the next movement
  always_ff @(posedge clk)
  begin
    if (rst)
      pause_cnt <= 16'h0000;
    else if (state == jmc_pkg::ST_IDLE && start_ok)
      pause_cnt <= sif.pause_ms;
    else if (state == jmc_pkg::ST_PAUSE && sif.tick_ms && pause_cnt != 16'h0000)
      pause_cnt <= pause_cnt - 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sif.step_start <= 1'b0;
    else
      sif.step_start <= (state == jmc_pkg::ST_IDLE) && start_ok && sif.step_mode;
  end

  sequence s_step_held;
    state == jmc_pkg::ST_STEP && !sif.abort && sif.pos_reached && held;
  endsequence
  sequence s_pause_then_cont;
    state == jmc_pkg::ST_PAUSE ##[1:1000] state == jmc_pkg::ST_CONT;
  endsequence

  AST_STEP_PAUSE: assert property (@(posedge clk) disable iff (rst)
    s_step_held |=> state == jmc_pkg::ST_PAUSE) else $error("held step did not pause");
  AST_PAUSE_LEN: assert property (@(posedge clk) disable iff (rst)
    (state == jmc_pkg::ST_PAUSE && pause_cnt > 16'h0001 && sif.tick_ms)
    |=> state != jmc_pkg::ST_CONT) else $error("pause ended early");
  AST_BRIEF_STOP: assert property (@(posedge clk) disable iff (rst)
    (state == jmc_pkg::ST_STEP && !sif.abort && sif.pos_reached && !held)
    |=> state == jmc_pkg::ST_STOP) else $error("brief step did not stop");
  AST_CONT_HOLD: assert property (@(posedge clk) disable iff (rst)
    (state == jmc_pkg::ST_CONT && held && !sif.abort) |=> sif.run_cont)
    else $error("continuous move dropped while held");
  AST_CONT_RELEASE: assert property (@(posedge clk) disable iff (rst)
    (state == jmc_pkg::ST_CONT && !held) |=> !sif.run_cont ##0 $stable(sif.dir_neg))
    else $error("continuous move kept after release");
  AST_BOTH_NO_START: assert property (@(posedge clk) disable iff (rst)
    (state == jmc_pkg::ST_IDLE && sif.req_pos && sif.req_neg) |=> !sif.busy)
    else $error("move started on both directions");
  AST_STOP_WAIT: assert property (@(posedge clk) disable iff (rst)
    (state == jmc_pkg::ST_STOP && !sif.standstill) |=> sif.busy)
    else $error("terminated before standstill");
endmodule
`default_nettype wire

// File: verilog/jmc_top.sv
// Notes on behaviour
// - Mode byte low nibble picks mode: 1 jog, 2, 3, 4, 7.
// - Mode byte bits 4-6 hold the action code, bit 7 the toggle.
// - Mode byte write activates mode; reference write starts motion.
// - Request bit0 positive, bit1 negative, bit2 fast; range 0-7, immediate.
// - Both directions requested while idle starts nothing.
// - Both directions while moving are ignored; current move continues.
// - Continuous method moves while the direction request stays asserted.
// - Step method: brief request moves one step distance, then stops.
// - Held request: one step, pause time stop, then continuous motion.
// - Discrete inputs give enable, fault clear, reverse and forward jog.
// - Jog ends at standstill after release, zero word, halt/stop or error.
// - Status bit 14 clear while running, set when ended; 15 error; 13 zero.
// - Assigned fast/slow input selects between the two jog speeds.
// - Slow speed 1-13200 rpm, default 60, clamped to ramp limit.
// - Fast speed 1-13200 rpm, default 180, clamped to ramp limit.
// - Step distance 0 to 2147483647, default 1, used from next move.
// - Pause time 1-32767 ms, default 500, used from next move.
// - Mode reject flag set when a request is refused.
`timescale 1ns/100ps
`default_nettype none
module jmc_top #(
  parameter int unsigned CLK_PER_MS = jmc_pkg::CYCLES_PER_MS,
  parameter int unsigned SYNC_BITS = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [15:0] param_addr,
  input wire logic [31:0] param_wdata,
  output logic [31:0] param_rdata,
  output logic param_ack,
  output logic param_err,
  input wire logic mode_wr,
  input wire logic [7:0] mode_select_byte,
  input wire logic ref_wr,
  input wire logic [15:0] ref_word,
  output logic [7:0] mode_status_byte,
  output logic [15:0] drive_status_word,
  input wire logic power_enable_input,
  input wire logic fault_clear_input,
  input wire logic reverse_jog_input,
  input wire logic forward_jog_input,
  input wire logic fast_slow_input,
  input wire logic use_inputs,
  input wire logic fast_slow_assigned,
  input wire logic step_method,
  input wire logic halt_active,
  input wire logic quick_stop_active,
  input wire logic error_detected,
  input wire logic power_stage_on,
  input wire logic motor_standstill,
  input wire logic position_reached,
  input wire logic [15:0] ramp_speed_limit,
  output logic power_enable_cmd,
  output logic fault_reset_pulse,
  output logic move_step_start,
  output logic move_continuous,
  output logic move_negative,
  output logic [15:0] move_speed,
  output logic [31:0] move_distance
);
  jmc_seq_if sif ();

  logic [15:0] slow_jog_speed;
  logic [15:0] fast_jog_speed;
  logic [31:0] step_distance;
  logic [15:0] step_pause_time;
  logic [2:0] manual_move_request;
  logic [3:0] mode_code;
  logic mode_toggle_flag;
  logic toggle_seen;
  logic mode_reject_flag;
  logic [SYNC_BITS-1:0] pin_raw;
  logic [SYNC_BITS-1:0] sync1;
  logic [SYNC_BITS-1:0] sync2;
  logic [SYNC_BITS-1:0] sync3;
  logic [SYNC_BITS-1:0] pin_f;
  logic [SYNC_BITS-1:0] pin_d;
  logic fresh_mode;
  logic mode_ok;
  logic jog_mode;
  logic fast_sel;
  logic [15:0] speed_sel;
  logic [31:0] prescale;
  logic tick_ms;
  logic [15:0] next_status;

  assign pin_raw = {fast_slow_input, forward_jog_input, reverse_jog_input,
    fault_clear_input, power_enable_input};

  // Pins cross three flops; a change counts when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_BITS; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_f[gi] <= 1'b0;
          pin_d[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
            pin_f[gi] <= sync3[gi];
          pin_d[gi] <= pin_f[gi];
        end
      end
    end
  endgenerate

  function automatic jmc_pkg::jmc_reg_idx_t reg_decode(input logic [15:0] a);
    case (a)
      jmc_pkg::OFS_SLOW_SPEED: reg_decode = jmc_pkg::RI_SLOW;
      jmc_pkg::OFS_FAST_SPEED: reg_decode = jmc_pkg::RI_FAST;
      jmc_pkg::OFS_STEP_DIST: reg_decode = jmc_pkg::RI_DIST;
      jmc_pkg::OFS_PAUSE_TIME: reg_decode = jmc_pkg::RI_PAUSE;
      default: reg_decode = jmc_pkg::RI_NONE;
    endcase
  endfunction

  function automatic logic speed_in_range(input logic [31:0] v);
    speed_in_range = (v[31:16] == 16'h0000) && (v[15:0] >= jmc_pkg::SPEED_MIN)
      && (v[15:0] <= jmc_pkg::SPEED_MAX);
  endfunction

  // Parameter writes outside the accepted range are refused and leave the value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slow_jog_speed <= jmc_pkg::RST_SLOW_SPEED;
      fast_jog_speed <= jmc_pkg::RST_FAST_SPEED;
      step_distance <= jmc_pkg::RST_STEP_DIST;
      step_pause_time <= jmc_pkg::RST_PAUSE_TIME;
    end
    else if (param_wr)
      case (reg_decode(param_addr))
        jmc_pkg::RI_SLOW:
          if (speed_in_range(param_wdata))
            slow_jog_speed <= param_wdata[15:0];
        jmc_pkg::RI_FAST:
          if (speed_in_range(param_wdata))
            fast_jog_speed <= param_wdata[15:0];
        jmc_pkg::RI_DIST:
          if (!param_wdata[31])
            step_distance <= param_wdata;
        jmc_pkg::RI_PAUSE:
          if (param_wdata[31:16] == 16'h0000 && param_wdata[15:0] >= jmc_pkg::PAUSE_MIN
              && param_wdata[15:0] <= jmc_pkg::PAUSE_MAX)
            step_pause_time <= param_wdata[15:0];
        default:
          slow_jog_speed <= slow_jog_speed;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      param_ack <= 1'b0;
      param_err <= 1'b0;
      param_rdata <= 32'h00000000;
    end
    else
    begin
      param_ack <= param_wr || param_rd;
      param_err <= 1'b0;
      if (param_rd)
        case (reg_decode(param_addr))
          jmc_pkg::RI_SLOW: param_rdata <= {16'h0000, slow_jog_speed};
          jmc_pkg::RI_FAST: param_rdata <= {16'h0000, fast_jog_speed};
          jmc_pkg::RI_DIST: param_rdata <= step_distance;
          jmc_pkg::RI_PAUSE: param_rdata <= {16'h0000, step_pause_time};
          default:
          begin
            param_rdata <= 32'h00000000;
            param_err <= 1'b1;
          end
        endcase
      else if (param_wr)
        case (reg_decode(param_addr))
          jmc_pkg::RI_SLOW, jmc_pkg::RI_FAST: param_err <= !speed_in_range(param_wdata);
          jmc_pkg::RI_DIST: param_err <= param_wdata[31];
          jmc_pkg::RI_PAUSE: param_err <= (param_wdata[31:16] != 16'h0000)
            || (param_wdata[15:0] < jmc_pkg::PAUSE_MIN)
            || (param_wdata[15:0] > jmc_pkg::PAUSE_MAX);
          default: param_err <= 1'b1;
        endcase
    end
  end

  // First write after reset always counts as fresh
  assign fresh_mode = mode_wr && (!toggle_seen
    || mode_select_byte[jmc_pkg::MSB_TOGGLE] != mode_toggle_flag);

  always_comb
  begin
    case (mode_select_byte[3:0])
      jmc_pkg::MODE_JOG:
        mode_ok = mode_select_byte[jmc_pkg::MSB_ACTION_HI:jmc_pkg::MSB_ACTION_LO]
          == jmc_pkg::JOG_ACTION;
      jmc_pkg::MODE_HOMING, jmc_pkg::MODE_PROFILE_POS, jmc_pkg::MODE_PROFILE_VEL,
      jmc_pkg::MODE_SPEED_CTRL:
        mode_ok = 1'b1;
      default:
        mode_ok = 1'b0;
    endcase
  end

  assign jog_mode = (mode_code == jmc_pkg::MODE_JOG);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_toggle_flag <= 1'b0;
      toggle_seen <= 1'b0;
    end
    else if (fresh_mode)
    begin
      mode_toggle_flag <= mode_select_byte[jmc_pkg::MSB_TOGGLE];
      toggle_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_code <= 4'h0;
    else if (fresh_mode && mode_ok)
      mode_code <= mode_select_byte[3:0];
  end

  // A fresh mode write arms the mode only; motion waits for a reference write
  always_ff @(posedge clk)
  begin
    if (rst)
      manual_move_request <= jmc_pkg::RST_MOVE_REQ;
    else if (fresh_mode && mode_ok)
      manual_move_request <= jmc_pkg::RST_MOVE_REQ;
    else if (ref_wr && jog_mode && ref_word <= jmc_pkg::MOVE_REQ_MAX)
      manual_move_request <= ref_word[2:0];
  end

  // Refusal sets the flag; a later accepted mode write clears it, set wins
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_reject_flag <= 1'b0;
    else if ((fresh_mode && !mode_ok)
             || (ref_wr && jog_mode && ref_word > jmc_pkg::MOVE_REQ_MAX))
      mode_reject_flag <= 1'b1;
    else if (fresh_mode)
      mode_reject_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_status_byte <= 8'h00;
    else
    begin
      mode_status_byte <= 8'h00;
      mode_status_byte[3:0] <= mode_code;
      mode_status_byte[jmc_pkg::MSTAT_REJECT] <= mode_reject_flag;
      mode_status_byte[jmc_pkg::MSB_TOGGLE] <= mode_toggle_flag;
    end
  end

  // Enable follows input edges, fault clear is a pulse on the rising edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      power_enable_cmd <= 1'b0;
      fault_reset_pulse <= 1'b0;
    end
    else
    begin
      if (pin_f[0] && !pin_d[0])
        power_enable_cmd <= 1'b1;
      else if (!pin_f[0] && pin_d[0])
        power_enable_cmd <= 1'b0;
      fault_reset_pulse <= pin_f[1] && !pin_d[1];
    end
  end

  // Request source: discrete inputs or the fieldbus request word
  assign sif.req_pos = use_inputs ? pin_f[3]
    : (jog_mode && manual_move_request[jmc_pkg::REQ_POS]);
  assign sif.req_neg = use_inputs ? pin_f[2]
    : (jog_mode && manual_move_request[jmc_pkg::REQ_NEG]);
  assign sif.step_mode = step_method;
  assign sif.abort = halt_active || quick_stop_active || error_detected
    || !power_stage_on || (!use_inputs && !jog_mode);
  assign sif.pos_reached = position_reached;
  assign sif.standstill = motor_standstill;
  assign sif.tick_ms = tick_ms;
  assign sif.pause_ms = step_pause_time;

  jmc_step_seq u_seq (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescale <= 32'h00000000;
      tick_ms <= 1'b0;
    end
    else if (prescale >= CLK_PER_MS - 1)
    begin
      prescale <= 32'h00000000;
      tick_ms <= 1'b1;
    end
    else
    begin
      prescale <= prescale + 32'h00000001;
      tick_ms <= 1'b0;
    end
  end

  assign fast_sel = fast_slow_assigned ? pin_f[4]
    : (!use_inputs && manual_move_request[jmc_pkg::REQ_FAST]);
  assign speed_sel = fast_sel ? fast_jog_speed : slow_jog_speed;

  always_ff @(posedge clk)
  begin
    if (rst)
      move_speed <= 16'h0000;
    else if (speed_sel > ramp_speed_limit)
      move_speed <= ramp_speed_limit;
    else
      move_speed <= speed_sel;
  end

  // Distance frozen for the duration of a movement
  always_ff @(posedge clk)
  begin
    if (rst)
      move_distance <= jmc_pkg::RST_STEP_DIST;
    else if (!sif.busy)
      move_distance <= step_distance;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      move_step_start <= 1'b0;
      move_continuous <= 1'b0;
      move_negative <= 1'b0;
    end
    else
    begin
      move_step_start <= sif.step_start;
      move_continuous <= sif.run_cont;
      move_negative <= sif.dir_neg;
    end
  end

  always_comb
  begin
    next_status = 16'h0000;
    next_status[jmc_pkg::DST_END] = !sif.busy;
    next_status[jmc_pkg::DST_ERR] = error_detected;
    next_status[jmc_pkg::DST_INFO] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      drive_status_word <= 16'h4000;
    else
      drive_status_word <= next_status;
  end

  AST_TOGGLE_REPEAT: assert property (@(posedge clk) disable iff (rst)
    (mode_wr && toggle_seen && mode_select_byte[7] == mode_toggle_flag && !ref_wr)
    |=> $stable(mode_code) ##0 $stable(mode_reject_flag)) else $error("repeat write acted");
  AST_REJECT_SET: assert property (@(posedge clk) disable iff (rst)
    (fresh_mode && !mode_ok) |=> ##1 mode_status_byte[6])
    else $error("refused mode not flagged");
  AST_END_FLAG: assert property (@(posedge clk) disable iff (rst)
    sif.busy |=> !drive_status_word[14] && !drive_status_word[13])
    else $error("end flag set while running");
  AST_SPEED_CLAMP: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> move_speed <= $past(ramp_speed_limit)) else $error("speed above ramp limit");
endmodule
`default_nettype wire

// File: tb/jmc_motor.sv
`timescale 1ns/100ps
`default_nettype none
module jmc_motor (
  input wire logic clk,
  input wire logic rst,
  input wire logic move_step_start,
  input wire logic move_continuous,
  output logic motor_standstill,
  output logic position_reached
);
  logic [2:0] step_left;
  // A step takes six cycles of travel
  always_ff @(posedge clk)
  begin
    if (rst)
      step_left <= 3'h0;
    else if (move_step_start)
      step_left <= 3'h6;
    else if (step_left != 3'h0)
      step_left <= step_left - 3'h1;
  end
  assign position_reached = step_left == 3'h1;
  assign motor_standstill = step_left == 3'h0 && !move_continuous;
endmodule
`default_nettype wire

// File: tb/jmc_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module jmc_top_test;
  logic clk, rst, param_wr, param_rd, param_ack, param_err, mode_wr, ref_wr, tg;
  logic [15:0] param_addr, ref_word, drive_status_word, move_speed, ramp_lim;
  logic [31:0] param_wdata, param_rdata, move_distance;
  logic [7:0] mode_select_byte, mode_status_byte;
  logic pwr_in, fwd_in, fast_in, use_inputs, fs_asg, step_method, halt, err_in;
  logic pwr_cmd, step_start, cont, neg, standstill, reached;
  logic rev_in, flt_in, qstop, frp;
  logic [3:0] modes [4] = '{4'h2, 4'h3, 4'h4, 4'h7};
  int n_errors, check_count;
  jmc_top #(.CLK_PER_MS(10)) dut (.clk(clk), .rst(rst), .param_wr(param_wr),
    .param_rd(param_rd), .param_addr(param_addr), .param_wdata(param_wdata),
    .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
    .mode_wr(mode_wr), .mode_select_byte(mode_select_byte), .ref_wr(ref_wr),
    .ref_word(ref_word), .mode_status_byte(mode_status_byte),
    .drive_status_word(drive_status_word), .power_enable_input(pwr_in),
    .fault_clear_input(flt_in), .reverse_jog_input(rev_in), .forward_jog_input(fwd_in),
    .fast_slow_input(fast_in), .use_inputs(use_inputs), .fast_slow_assigned(fs_asg),
    .step_method(step_method), .halt_active(halt), .quick_stop_active(qstop),
    .error_detected(err_in), .power_stage_on(1'b1), .motor_standstill(standstill),
    .position_reached(reached), .ramp_speed_limit(ramp_lim), .power_enable_cmd(pwr_cmd),
    .fault_reset_pulse(frp), .move_step_start(step_start), .move_continuous(cont),
    .move_negative(neg), .move_speed(move_speed), .move_distance(move_distance));
  jmc_motor motor (.clk(clk), .rst(rst), .move_step_start(step_start),
    .move_continuous(cont), .motor_standstill(standstill), .position_reached(reached));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic prm(input logic wr, input logic [15:0] a, input logic [31:0] d,
    input logic e, input logic [31:0] r);
    @(negedge clk);
    param_wr = wr;
    param_rd = !wr;
    param_addr = a;
    param_wdata = d;
    @(negedge clk);
    param_wr = 1'b0;
    param_rd = 1'b0;
    for (int k = 0; k < 3 && param_ack !== 1'b1; k++)
      @(negedge clk);
    chk("ack", 1, param_ack);
    chk("err", e, param_err);
    if (!wr)
      chk("rdata", r, param_rdata);
  endtask
  task automatic mset(input logic [7:0] b, input logic [7:0] st);
    @(negedge clk);
    mode_wr = 1'b1;
    mode_select_byte = b;
    @(negedge clk);
    mode_wr = 1'b0;
    tick(2);
    chk("mode_status", st, mode_status_byte);
  endtask
  task automatic rset(input logic [15:0] w);
    @(negedge clk);
    ref_wr = 1'b1;
    ref_word = w;
    @(negedge clk);
    ref_wr = 1'b0;
  endtask
  task automatic wait_step;
    for (int k = 0; k < 8 && step_start !== 1'b1; k++)
      @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    {rst, param_wr, param_rd, mode_wr, ref_wr, pwr_in, fwd_in, fast_in} = 8'h80;
    {use_inputs, fs_asg, step_method, halt, err_in, rev_in, flt_in, qstop} = 8'h00;
    {param_addr, ref_word, param_wdata, mode_select_byte} = '0;
    ramp_lim = 16'hffff;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("status", 32'h4000, drive_status_word);
    prm(0, jmc_pkg::OFS_SLOW_SPEED, 0, 0, 32'h3c);
    prm(0, jmc_pkg::OFS_FAST_SPEED, 0, 0, 32'hb4);
    prm(0, jmc_pkg::OFS_STEP_DIST, 0, 0, 32'h1);
    prm(0, jmc_pkg::OFS_PAUSE_TIME, 0, 0, 32'h1f4);
    prm(1, jmc_pkg::OFS_SLOW_SPEED, 0, 1, 0);
    prm(1, jmc_pkg::OFS_FAST_SPEED, 32'h3391, 1, 0);
    prm(1, jmc_pkg::OFS_STEP_DIST, 32'h80000000, 1, 0);
    prm(1, jmc_pkg::OFS_PAUSE_TIME, 32'h8000, 1, 0);
    prm(0, 16'h290c, 0, 1, 0);
    prm(1, jmc_pkg::OFS_SLOW_SPEED, 32'h3390, 0, 0);
    prm(0, jmc_pkg::OFS_SLOW_SPEED, 0, 0, 32'h3390);
    prm(1, jmc_pkg::OFS_SLOW_SPEED, 32'h64, 0, 0);
    prm(1, jmc_pkg::OFS_STEP_DIST, 32'h7fffffff, 0, 0);
    prm(1, jmc_pkg::OFS_PAUSE_TIME, 32'h2, 0, 0);
    mset(8'h81, 8'h81);
    mset(8'h82, 8'h81);
    mset(8'h05, 8'h41);
    mset(8'h91, 8'hc1);
    tg = 1'b1;
    foreach (modes[k])
    begin
      tg = !tg;
      mset({tg, 3'h0, modes[k]}, {tg, 3'h0, modes[k]});
    end
    rset(1);
    tick(5);
    chk("cont", 0, cont);
    mset(8'h01, 8'h01);
    chk("cont", 0, cont);
    rset(16'h0008);
    tick(2);
    chk("mode_status", 8'h41, mode_status_byte);
    rset(1);
    tick(3);
    chk("cont", 1, cont);
    chk("neg", 0, neg);
    chk("speed", 32'h64, move_speed);
    chk("end", 0, drive_status_word[14]);
    rset(5);
    tick(3);
    chk("speed", 32'hb4, move_speed);
    rset(7);
    tick(4);
    chk("cont", 1, cont);
    chk("neg", 0, neg);
    rset(0);
    tick(8);
    chk("cont", 0, cont);
    chk("end", 1, drive_status_word[14]);
    rset(3);
    tick(8);
    chk("cont", 0, cont);
    chk("end", 1, drive_status_word[14]);
    rset(0);
    step_method = 1'b1;
    rset(2);
    wait_step();
    chk("step", 1, step_start);
    chk("neg", 1, neg);
    chk("dist", 32'h7fffffff, move_distance);
    tick(6);
    chk("cont", 0, cont);
    tick(30);
    chk("cont", 1, cont);
    rset(0);
    tick(10);
    rset(1);
    wait_step();
    chk("step", 1, step_start);
    rset(0);
    tick(40);
    chk("cont", 0, cont);
    chk("end", 1, drive_status_word[14]);
    step_method = 1'b0;
    rset(1);
    tick(4);
    halt = 1'b1;
    tick(8);
    chk("cont", 0, cont);
    chk("end", 1, drive_status_word[14]);
    halt = 1'b0;
    tick(4);
    chk("cont", 1, cont);
    qstop = 1'b1;
    tick(8);
    chk("cont", 0, cont);
    qstop = 1'b0;
    rset(0);
    err_in = 1'b1;
    tick(3);
    chk("err", 1, drive_status_word[15]);
    err_in = 1'b0;
    tick(3);
    use_inputs = 1'b1;
    pwr_in = 1'b1;
    fwd_in = 1'b1;
    tick(10);
    chk("enable", 1, pwr_cmd);
    chk("cont", 1, cont);
    chk("speed", 32'h64, move_speed);
    fs_asg = 1'b1;
    fast_in = 1'b1;
    tick(10);
    chk("speed", 32'hb4, move_speed);
    ramp_lim = 16'h0032;
    tick(3);
    chk("speed", 32'h32, move_speed);
    fwd_in = 1'b0;
    tick(12);
    chk("cont", 0, cont);
    pwr_in = 1'b0;
    tick(10);
    chk("enable", 0, pwr_cmd);
    rev_in = 1'b1;
    tick(10);
    chk("cont", 1, cont);
    chk("neg", 1, neg);
    rev_in = 1'b0;
    flt_in = 1'b1;
    for (int k = 0; k < 10 && frp !== 1'b1; k++)
      @(negedge clk);
    chk("fault_reset", 1, frp);
    tick(1);
    chk("fault_reset", 0, frp);
    give_verdict();
  end
endmodule
`default_nettype wire
